/* File: core/cal_pkg.sv */
// Shared constants, types and helpers for the channel A active line length block.
package cal_pkg;

	// Widths of the pixel path and of the line length value.
	localparam int PIX_W = 24;
	localparam int LEN_W = 12;
	localparam int LOW_W = 8;
	localparam int HIGH_W = 4;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [5:0] IDX_LEN_LOW = 6'h20;
	localparam logic [5:0] IDX_LEN_HIGH = 6'h21;
	localparam logic [5:0] IDX_CONFIG = 6'h30;
	localparam logic [5:0] IDX_TRIM = 6'h31;
	localparam logic [5:0] IDX_STATUS = 6'h32;
	localparam logic [5:0] IDX_LAST_LOW = 6'h33;
	localparam logic [5:0] IDX_LAST_HIGH = 6'h34;

	// Reset values.
	localparam logic [7:0] RST_LEN_LOW = 8'h00;
	localparam logic [7:0] RST_LEN_HIGH = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h01;
	localparam logic [7:0] RST_TRIM = 8'h00;

	// Field positions in the configuration register.
	localparam int CFG_SINGLE_LINK = 0;
	localparam int CFG_DUAL_INPUT = 1;
	localparam int CFG_MODE_LSB = 2;
	localparam int CFG_MODE_MSB = 3;

	// Field positions in the status register.
	localparam int ST_ACTIVE = 0;
	localparam int ST_OVERFLOW = 1;
	localparam int ST_SHORT = 2;
	localparam int ST_LONG = 3;

	// Input channel arrangement codes.
	localparam logic [1:0] MODE_TWO_STREAM = 2'h2;
	localparam logic [1:0] MODE_LEFT_RIGHT = 2'h3;

	typedef enum logic [1:0] {
		ARR_SINGLE,
		ARR_ODD_EVEN,
		ARR_LEFT_RIGHT,
		ARR_TWO_STREAM
	} cal_arr_type;

	typedef struct packed {
		logic [PIX_W-1:0] data;
		logic last;
		logic to_a;
		logic to_b;
	} cal_pixel_type;

	// Two-stream needs dual input, both output links and the two-stream code; with dual input on a single link that code falls back to odd/even.
	function automatic cal_arr_type cal_decode_arr(input logic dual_input, input logic single_link,
		input logic [1:0] mode);
		cal_arr_type arr;
		arr = ARR_SINGLE;
		if (dual_input) begin
			if (mode == MODE_LEFT_RIGHT) begin
				arr = ARR_LEFT_RIGHT;
			end else if (mode == MODE_TWO_STREAM && !single_link) begin
				arr = ARR_TWO_STREAM;
			end else begin
				arr = ARR_ODD_EVEN;
			end
		end
		return arr;
	endfunction

endpackage

/* File: core/cal_pix_buf.sv */
// Two-entry pixel buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module cal_pix_buf
	import cal_pkg::*;
#(
	parameter int W = $bits(cal_pixel_type)
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	logic v1_r;
	logic [W-1:0] d1_r;
	logic push;
	logic pop;

	// Slot 0 is always the head, so the outputs come straight from flip-flops.
	assign in_ready = !v1_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data <= '0;
			v1_r <= 1'b0;
			d1_r <= '0;
		end else if (pop) begin
			if (v1_r) begin
				out_data <= d1_r;
				v1_r <= 1'b0;
			end else begin
				out_valid <= push;
				out_data <= in_data;
			end
		end else if (push) begin
			if (!out_valid) begin
				out_valid <= 1'b1;
				out_data <= in_data;
			end else begin
				v1_r <= 1'b1;
				d1_r <= in_data;
			end
		end
	end

endmodule
`default_nettype wire

/* File: core/cal_line_length.sv */
// Channel A active line length registers and the pixel counter and router they steer.
`timescale 1ns/10ps
`default_nettype none
module cal_line_length
	import cal_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Classic Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Video input from the serial receiver, asynchronous to clk_sys
	input wire logic link_clk,
	input wire logic link_de,
	input wire logic [PIX_W-1:0] link_data,
	// Routed pixel stream towards the output links
	output logic pix_valid,
	input wire logic pix_ready,
	output logic [PIX_W-1:0] pix_data,
	output logic pix_last,
	output logic pix_to_a,
	output logic pix_to_b,
	// Effective length for the rest of the bridge
	output logic [LEN_W-1:0] line_length
);

	typedef enum logic [1:0] {
		LN_IDLE,
		LN_TRIM,
		LN_PASS,
		LN_EXCESS
	} cal_line_state_type;

	// Register file.
	logic [7:0] len_low_r;
	logic [7:0] len_high_r;
	logic [7:0] config_r;
	logic [7:0] trim_r;
	logic overflow_r;
	logic short_r;
	logic long_r;
	logic [LEN_W-1:0] last_count_r;
	logic bus_req;
	logic bus_wr;
	logic [5:0] bus_idx;

	// Synchronisers and edge finding.
	logic lclk_s1_r;
	logic lclk_s2_r;
	logic lclk_s3_r;
	logic de_s1_r;
	logic de_s2_r;
	logic [PIX_W-1:0] data_s1_r;
	logic [PIX_W-1:0] data_s2_r;
	logic pix_edge;

	// Line tracking.
	cal_line_state_type state_r;
	cal_line_state_type state_nxt;
	logic [LEN_W-1:0] limit_r;
	logic [LEN_W-1:0] limit_nxt;
	logic [LEN_W-1:0] count_r;
	logic [LEN_W-1:0] count_nxt;
	logic [7:0] trim_left_r;
	logic [7:0] trim_left_nxt;
	logic to_b_r;
	logic to_b_nxt;
	logic emit_nxt;
	logic emit_last_nxt;
	logic line_end;
	logic short_set;
	logic long_set;
	cal_arr_type arr_now;
	logic [LEN_W-1:0] len_field;

	// Emission into the buffer.
	logic emit_valid_r;
	cal_pixel_type emit_pix_r;
	cal_pixel_type out_pix;
	logic buf_ready;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	assign bus_idx = wb_adr_i[7:2];
	assign len_field = {len_high_r[HIGH_W-1:0], len_low_r};
	assign arr_now = cal_decode_arr(config_r[CFG_DUAL_INPUT], config_r[CFG_SINGLE_LINK],
		config_r[CFG_MODE_MSB:CFG_MODE_LSB]);

	// Bus answer: one wait state, every access acknowledged, unmapped reads give zero.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h00000000;
		end else if (bus_req) begin
			case (bus_idx)
				IDX_LEN_LOW: wb_dat_o <= {24'h000000, len_low_r};
				IDX_LEN_HIGH: wb_dat_o <= {28'h0000000, len_high_r[HIGH_W-1:0]};
				IDX_CONFIG: wb_dat_o <= {24'h000000, config_r};
				IDX_TRIM: wb_dat_o <= {24'h000000, trim_r};
				IDX_STATUS: wb_dat_o <= {28'h0000000, long_r, short_r, overflow_r, state_r != LN_IDLE};
				IDX_LAST_LOW: wb_dat_o <= {24'h000000, last_count_r[LOW_W-1:0]};
				IDX_LAST_HIGH: wb_dat_o <= {28'h0000000, last_count_r[LEN_W-1:LOW_W]};
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// Writable registers.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			len_low_r <= RST_LEN_LOW;
			len_high_r <= RST_LEN_HIGH;
			config_r <= RST_CONFIG;
			trim_r <= RST_TRIM;
		end else if (bus_wr) begin
			case (bus_idx)
				IDX_LEN_LOW: len_low_r <= wb_dat_i[7:0];
				IDX_LEN_HIGH: len_high_r <= {4'h0, wb_dat_i[HIGH_W-1:0]};
				IDX_CONFIG: config_r <= {4'h0, wb_dat_i[3:0]};
				IDX_TRIM: trim_r <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// Sticky status bits are cleared by writing one; a new event in the same cycle wins.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			overflow_r <= 1'b0;
			short_r <= 1'b0;
			long_r <= 1'b0;
		end else begin
			if (emit_valid_r && !buf_ready) begin
				overflow_r <= 1'b1;
			end else if (bus_wr && bus_idx == IDX_STATUS && wb_dat_i[ST_OVERFLOW]) begin
				overflow_r <= 1'b0;
			end
			if (short_set) begin
				short_r <= 1'b1;
			end else if (bus_wr && bus_idx == IDX_STATUS && wb_dat_i[ST_SHORT]) begin
				short_r <= 1'b0;
			end
			if (long_set) begin
				long_r <= 1'b1;
			end else if (bus_wr && bus_idx == IDX_STATUS && wb_dat_i[ST_LONG]) begin
				long_r <= 1'b0;
			end
		end
	end

	// The link clock is only sampled; its rising edge marks a pixel.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lclk_s1_r <= 1'b0;
			lclk_s2_r <= 1'b0;
			lclk_s3_r <= 1'b0;
			de_s1_r <= 1'b0;
			de_s2_r <= 1'b0;
			data_s1_r <= '0;
			data_s2_r <= '0;
		end else begin
			lclk_s1_r <= link_clk;
			lclk_s2_r <= lclk_s1_r;
			lclk_s3_r <= lclk_s2_r;
			de_s1_r <= link_de;
			de_s2_r <= de_s1_r;
			data_s1_r <= link_data;
			data_s2_r <= data_s1_r;
		end
	end

	// Data must be stable around the link's rising edge; it passes the same two stages as the clock.
	assign pix_edge = lclk_s2_r && !lclk_s3_r;

	// Per-pixel decision; a new line latches length, trim and routing at its first pixel.
	always_comb begin
		logic [LEN_W-1:0] lim;
		logic [LEN_W-1:0] cnt;
		logic [7:0] trm;
		lim = limit_r;
		cnt = count_r;
		trm = trim_left_r;
		state_nxt = state_r;
		limit_nxt = limit_r;
		count_nxt = count_r;
		trim_left_nxt = trim_left_r;
		to_b_nxt = to_b_r;
		emit_nxt = 1'b0;
		emit_last_nxt = 1'b0;
		line_end = 1'b0;
		if (pix_edge) begin
			if (!de_s2_r) begin
				line_end = (state_r != LN_IDLE);
				state_nxt = LN_IDLE;
			end else begin
				if (state_r == LN_IDLE) begin
					lim = len_field;
					cnt = '0;
					trm = (arr_now == ARR_LEFT_RIGHT) ? trim_r : 8'h00;
					limit_nxt = lim;
					to_b_nxt = (arr_now == ARR_ODD_EVEN) && !config_r[CFG_SINGLE_LINK];
				end
				case (state_r)
					LN_IDLE, LN_TRIM, LN_PASS: begin
						if (trm != 8'h00) begin
							trim_left_nxt = trm - 8'h01;
							count_nxt = cnt;
							state_nxt = LN_TRIM;
						end else if (cnt < lim) begin
							emit_nxt = 1'b1;
							emit_last_nxt = (cnt == lim - 12'h001);
							count_nxt = cnt + 12'h001;
							trim_left_nxt = 8'h00;
							state_nxt = LN_PASS;
						end else begin
							count_nxt = cnt;
							trim_left_nxt = 8'h00;
							state_nxt = LN_EXCESS;
						end
					end
					LN_EXCESS: state_nxt = LN_EXCESS;
					default: state_nxt = LN_IDLE;
				endcase
			end
		end
	end

	assign short_set = line_end && (count_r < limit_r);
	assign long_set = pix_edge && de_s2_r && (state_r == LN_EXCESS || state_nxt == LN_EXCESS)
		&& state_r != LN_EXCESS;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= LN_IDLE;
			limit_r <= '0;
			count_r <= '0;
			trim_left_r <= 8'h00;
			to_b_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			limit_r <= limit_nxt;
			count_r <= count_nxt;
			trim_left_r <= trim_left_nxt;
			to_b_r <= to_b_nxt;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			last_count_r <= '0;
		end else if (line_end) begin
			last_count_r <= count_r;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			emit_valid_r <= 1'b0;
			emit_pix_r <= '0;
		end else begin
			emit_valid_r <= emit_nxt;
			if (emit_nxt) begin
				emit_pix_r.data <= data_s2_r;
				emit_pix_r.last <= emit_last_nxt;
				emit_pix_r.to_a <= 1'b1;
				emit_pix_r.to_b <= to_b_nxt;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			line_length <= '0;
		end else begin
			line_length <= len_field;
		end
	end

	// A stalled receiver is absorbed by two entries; a pixel that still finds no room is flagged.
	cal_pix_buf #(
		.W($bits(cal_pixel_type))
	) u_buf (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(emit_valid_r),
		.in_ready(buf_ready),
		.in_data(emit_pix_r),
		.out_valid(pix_valid),
		.out_ready(pix_ready),
		.out_data(out_pix)
	);

	assign pix_data = out_pix.data;
	assign pix_last = out_pix.last;
	assign pix_to_a = out_pix.to_a;
	assign pix_to_b = out_pix.to_b;

endmodule
`default_nettype wire

/* File: verification/cal_video_src.sv */
// Behavioural serial video source that feeds the block's link pins.
`timescale 1ns/10ps
`default_nettype none
module cal_video_src
	import cal_pkg::*;
(
	// Link pins
	output logic link_clk,
	output logic link_de,
	output logic [PIX_W-1:0] link_data
);
	initial begin
		link_clk = 1'b0;
		link_de = 1'b0;
		link_data = '0;
	end
	// The clock stands still between lines; blanking data is the last pixel inverted, then that same pixel again.
	task automatic send_line(input int n, input logic [PIX_W-1:0] base);
		// Shift off the system clock's edges so no pin changes in the step where it is sampled.
		#1;
		for (int i = 0; i < n + 2; i++) begin
			link_de = (i < n);
			link_data = (i < n) ? base + PIX_W'(i) : ~link_data;
			#40 link_clk = 1'b1;
			#40 link_clk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* File: verification/cal_line_length_properties.sv */
// Concurrent checks on the ports of the line length block.
`timescale 1ns/10ps
`default_nettype none
module cal_line_length_properties
	import cal_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pixel stream
	input wire logic pix_valid,
	input wire logic pix_ready,
	input wire logic [PIX_W-1:0] pix_data,
	input wire logic pix_last,
	input wire logic pix_to_a,
	input wire logic pix_to_b,
	input wire logic [LEN_W-1:0] line_length
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence wr_s(logic [5:0] idx);
		take_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == idx);
	endsequence
	sequence rd_s(logic [5:0] idx);
		take_s ##0 (!wb_we_i && wb_adr_i[7:2] == idx);
	endsequence
	ack_latency_a: assert property (take_s |=> wb_ack_o)
		else $error("ack missing after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	len_low_a: assert property (wr_s(IDX_LEN_LOW) |-> ##3 line_length[7:0] == $past(wb_dat_i[7:0], 3))
		else $error("low byte not in length");
	len_high_a: assert property (wr_s(IDX_LEN_HIGH) |-> ##3 line_length[11:8] == $past(wb_dat_i[3:0], 3))
		else $error("high nibble not in length");
	len_stable_a: assert property ((!(wb_cyc_i && wb_we_i))[*3] |=> $stable(line_length))
		else $error("length moved without write");
	read_low_a: assert property (rd_s(IDX_LEN_LOW) |=> wb_dat_o[7:0] == line_length[7:0])
		else $error("low byte read wrong");
	read_high_a: assert property (rd_s(IDX_LEN_HIGH) |=> wb_dat_o[7:0] == {4'h0, line_length[11:8]})
		else $error("high nibble read wrong");
	pix_hold_a: assert property (pix_valid && !pix_ready |=> pix_valid && $stable({pix_data, pix_last, pix_to_b}))
		else $error("pixel changed while stalled");
	link_a_a: assert property (pix_valid |-> pix_to_a)
		else $error("pixel not routed to link A");
endmodule
bind cal_line_length cal_line_length_properties cal_line_length_properties_inst(.clk_sys(clk_sys), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_valid(pix_valid), .pix_ready(pix_ready),
	.pix_data(pix_data), .pix_last(pix_last), .pix_to_a(pix_to_a), .pix_to_b(pix_to_b), .line_length(line_length));
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the channel A line length block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import cal_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pix_ready = 1'b1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic wb_ack_o, link_clk, link_de, pix_valid, pix_last, pix_to_a, pix_to_b;
	logic [PIX_W-1:0] link_data, pix_data;
	logic [LEN_W-1:0] line_length;
	logic [PIX_W+2:0] seen[$];
	int fail_count = 0;
	int comparisons = 0;
	// Columns: config, trim, length, pixels sent, link B expected.
	int tab[8][5] = '{'{1, 0, 3, 3, 0}, '{3, 0, 2, 2, 0}, '{2, 0, 2, 2, 1}, '{6, 0, 1, 1, 1},
		'{10, 0, 2, 2, 0}, '{14, 1, 2, 3, 0}, '{1, 0, 2, 4, 0}, '{1, 0, 3, 2, 0}};
	always #2.5 clk_sys = ~clk_sys;
	cal_line_length cal_line_length_inst(.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .link_clk(link_clk), .link_de(link_de), .link_data(link_data), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .pix_data(pix_data), .pix_last(pix_last), .pix_to_a(pix_to_a), .pix_to_b(pix_to_b),
		.line_length(line_length));
	cal_video_src cal_video_src_inst(.link_clk(link_clk), .link_de(link_de), .link_data(link_data));
	always @(posedge clk_sys) begin
		if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
			seen.push_back({pix_data, pix_last, pix_to_a, pix_to_b});
		end
	end
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		// Only the acknowledge or the watchdog ends this wait; the slave answers one cycle after it takes the request.
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1);
		check("bus ack", n, 32'h2);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_sys);
		check("ack drop", wb_ack_o, 32'h0);
	endtask
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
	initial begin
		int k;
		logic [31:0] e;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		bus(0, IDX_LEN_LOW, 8'h00);
		check("len low", q, 32'h0);
		bus(0, IDX_LEN_HIGH, 8'h00);
		check("len high", q, 32'h0);
		bus(1, IDX_LEN_LOW, 8'h34);
		bus(1, IDX_LEN_HIGH, 8'hFA);
		bus(0, IDX_LEN_HIGH, 8'h00);
		check("len high", q, 32'h0A);
		check("length", 32'(line_length), 32'hA34);
		bus(1, 6'h3F, 8'hFF);
		bus(0, 6'h3F, 8'h00);
		check("unmapped", q, 32'h0);
		for (int r = 0; r < 8; r++) begin
			bus(1, IDX_CONFIG, 8'(tab[r][0]));
			bus(1, IDX_TRIM, 8'(tab[r][1]));
			bus(1, IDX_LEN_LOW, 8'(tab[r][2]));
			bus(1, IDX_LEN_HIGH, 8'h00);
			cal_video_src_inst.send_line(tab[r][3], PIX_W'(32'h100 * r));
			@(posedge clk_sys);
			k = (tab[r][3] - tab[r][1] < tab[r][2]) ? tab[r][3] - tab[r][1] : tab[r][2];
			check("count", seen.size(), k);
			for (int i = 0; i < k; i++) begin
				e = 32'({PIX_W'(32'h100 * r + tab[r][1] + i), i == tab[r][2] - 1, 1'b1, tab[r][4] != 0});
				check("pixel", 32'(seen[i]), e);
			end
			seen.delete();
			bus(0, IDX_LAST_LOW, 8'h00);
			check("last count", q, k);
		end
		bus(0, IDX_STATUS, 8'h00);
		check("status", q, 32'h0C);
		bus(1, IDX_STATUS, 8'h0C);
		bus(0, IDX_STATUS, 8'h00);
		check("status", q, 32'h0);
		// A stalled receiver keeps both buffered words; only the third is lost.
		pix_ready <= 1'b0;
		bus(1, IDX_LEN_LOW, 8'h03);
		cal_video_src_inst.send_line(3, 24'h700);
		@(posedge clk_sys);
		bus(0, IDX_STATUS, 8'h00);
		check("overflow", q, 32'h02);
		pix_ready <= 1'b1;
		for (int n = 0; n < 20 && seen.size() < 2; n++) @(posedge clk_sys);
		check("drain 0", 32'(seen[0]), {24'h700, 3'b010});
		check("drain 1", 32'(seen[1]), {24'h701, 3'b010});
		finish_test();
	end
endmodule
`default_nettype wire
